// *** logic/bch_config_regs.sv ***
// configuration header registers, offsets 08h to 14h, primary side only
// Notes on behaviour
// - offset 08h top byte reads base class 06h, read-only
// - sub-class byte reads 04h, read-only
// - programming interface byte always reads zero
// - low byte of 08h is a fixed read-only revision
// - top byte of 0Ch is reserved, reads zero
// - header type reads 01h, selecting bridge layout
// - 0Ch bits 15:8 limit primary master clocks from frame start
// - only latency bits 15:11 writable, 10:8 read zero
// - zero latency disables the timer; field resets to zero
// - cache line size writable in 0Ch bits 7:0, resets zero
// - effective line size is the highest set bit only
// - effective line size ends write-invalidate and sizes prefetch
// - words 10h and 14h read zero, writes ignored
// - accesses come only from the primary bus side
module bch_config_regs
  import bch_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h00 // arbitrary value
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // primary side configuration access
  input wire logic cfgSel,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn_n,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  // primary master timing
  input wire logic frameStart,
  input wire logic frameActive,
  output logic latTimerExpired,
  output logic latTimerEnabled,
  // cache line users
  output logic [7:0] lineSizeWords,
  output logic [7:0] lineSizeMask,
  input wire logic [7:0] burstWordCount,
  output logic mwiLineEnd,
  output logic [7:0] prefetchWords
);
  logic rstMeta_r;
  logic rstSync_r;
  logic [BCH_LAT_W-1:0] latLimit_r;
  logic [BCH_LAT_W-1:0] latLimit_nxt;
  logic [7:0] lineSize_r;
  logic [7:0] lineSize_nxt;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic [7:0] effLine;

  // highest set bit of the cache line field as a power of two
  function automatic logic [7:0] msb_only(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 8'h01 << i;
      end
    end
    return r;
  endfunction : msb_only

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // cfgSel is only ever driven by the primary-side decoder
  always_comb begin
    latLimit_nxt = latLimit_r;
    lineSize_nxt = lineSize_r;
    rdData_nxt = rdData_r;
    if (cfgSel && cfgWrite && cfgAddr == BCH_OFF_LATCL) begin
      if (!cfgByteEn_n[1]) begin
        latLimit_nxt = cfgWrData[BCH_LAT_LSB +: BCH_LAT_W];
      end
      if (!cfgByteEn_n[0]) begin
        lineSize_nxt = cfgWrData[7:0];
      end
    end
    if (cfgSel && !cfgWrite) begin
      unique case (cfgAddr)
        BCH_OFF_CLASS: begin
          rdData_nxt = {BCH_BASE_CLASS, BCH_SUB_CLASS, BCH_PROG_IF, REVISION};
        end
        BCH_OFF_LATCL: begin
          rdData_nxt = {BCH_RSVD_BYTE, BCH_HDR_TYPE, latLimit_r,
                        {BCH_LAT_GRAN_BITS{1'b0}}, lineSize_r};
        end
        default: begin
          rdData_nxt = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstSync_r) begin
    if (!rstSync_r) begin
      latLimit_r <= BCH_LAT_RESET;
      lineSize_r <= BCH_CLS_RESET;
      rdData_r <= 32'h00000000;
    end else begin
      latLimit_r <= latLimit_nxt;
      lineSize_r <= lineSize_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign cfgRdData = rdData_r;

  bch_latency_timer uTimer (
    .mclk(mclk),
    .rstSync_n(rstSync_r),
    .latLimit(latLimit_r),
    .frameStart(frameStart),
    .frameActive(frameActive),
    .timerExpired(latTimerExpired)
  );

  assign latTimerEnabled = (latLimit_r != 5'h00);

  // lower set bits are ignored so software slips cannot give odd sizes
  assign effLine = msb_only(lineSize_r);
  assign lineSizeWords = effLine;
  assign lineSizeMask = effLine - 8'h01;
  // write-invalidate ends on a line boundary; zero size never ends it early
  assign mwiLineEnd = (effLine != 8'h00) &&
                      ((burstWordCount & (effLine - 8'h01)) == (effLine - 8'h01));
  assign prefetchWords = effLine;
endmodule : bch_config_regs

// *** logic/bch_latency_timer.sv ***
// primary master latency timer counting clocks from frame assertion
module bch_latency_timer
  import bch_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstSync_n,
  // control
  input wire logic [BCH_LAT_W-1:0] latLimit,
  input wire logic frameStart,
  input wire logic frameActive,
  // status
  output logic timerExpired
);
  logic [BCH_CNT_W-1:0] count_r;
  logic [BCH_CNT_W-1:0] count_nxt;
  logic expired_r;
  logic expired_nxt;
  logic [BCH_CNT_W-1:0] limitClocks;

  // limit is in steps of eight clocks, low bits always zero
  assign limitClocks = {latLimit, {BCH_LAT_GRAN_BITS{1'b0}}};

  always_comb begin
    count_nxt = count_r;
    expired_nxt = expired_r;
    if (frameStart) begin
      count_nxt = 8'h01;
      expired_nxt = 1'b0;
    end else if (!frameActive) begin
      count_nxt = 8'h00;
      expired_nxt = 1'b0;
    end else if (latLimit == 5'h00) begin
      expired_nxt = 1'b0;
    end else if (count_r >= limitClocks) begin
      expired_nxt = 1'b1;
    end else begin
      count_nxt = count_r + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      count_r <= 8'h00;
      expired_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign timerExpired = expired_r;
endmodule : bch_latency_timer

// *** logic/bch_pkg.sv ***
// constants for the bridge configuration header registers
package bch_pkg;
  localparam logic [7:0] BCH_OFF_CLASS = 8'h08;
  localparam logic [7:0] BCH_OFF_LATCL = 8'h0c;
  localparam logic [7:0] BCH_OFF_RSVDA = 8'h10;
  localparam logic [7:0] BCH_OFF_RSVDB = 8'h14;
  localparam logic [7:0] BCH_BASE_CLASS = 8'h06;
  localparam logic [7:0] BCH_SUB_CLASS = 8'h04;
  localparam logic [7:0] BCH_PROG_IF = 8'h00;
  localparam logic [7:0] BCH_HDR_TYPE = 8'h01;
  localparam logic [7:0] BCH_RSVD_BYTE = 8'h00;
  localparam logic [4:0] BCH_LAT_RESET = 5'h00;
  localparam logic [7:0] BCH_CLS_RESET = 8'h00;
  localparam int BCH_LAT_LSB = 11;
  localparam int BCH_LAT_W = 5;
  localparam int BCH_LAT_GRAN_BITS = 3;
  localparam int BCH_CNT_W = 8;
endpackage : bch_pkg

// *** verification/bch_cfg_chk_properties.sv ***
// assertions on the config header ports
module bch_cfg_chk
  import bch_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cfgSel,
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [31:0] cfgRdData,
  input wire logic frameActive,
  input wire logic latTimerExpired,
  input wire logic latTimerEnabled,
  input wire logic [7:0] lineSizeWords,
  input wire logic [7:0] lineSizeMask,
  input wire logic [7:0] prefetchWords
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence rdAt(a);
    cfgSel && !cfgWrite && cfgAddr == a;
  endsequence
  AST_CLASS: assert property (rdAt(BCH_OFF_CLASS) |=> cfgRdData[31:8] == 24'h060400)
    else $error("class bytes wrong");
  AST_HDR: assert property (rdAt(BCH_OFF_LATCL) |=> cfgRdData[31:16] == 16'h0001
    && cfgRdData[10:8] == 3'h0) else $error("header word wrong");
  AST_RSVD: assert property ((rdAt(BCH_OFF_RSVDA) or rdAt(BCH_OFF_RSVDB)) |=> cfgRdData == '0)
    else $error("reserved not zero");
  AST_HOLD: assert property (!(cfgSel && !cfgWrite) |=> $stable(cfgRdData))
    else $error("read data moved");
  AST_LINE: assert property ($onehot0(lineSizeWords) && lineSizeMask == lineSizeWords - 8'h01)
    else $error("line size not a power of two");
  AST_PREF: assert property (prefetchWords == lineSizeWords)
    else $error("prefetch size wrong");
  // two cycles: expiry is registered, the enable is not
  AST_OFF: assert property (!latTimerEnabled [*2] |-> !latTimerExpired)
    else $error("disabled timer expired");
  AST_DROP: assert property (!frameActive |=> !latTimerExpired)
    else $error("expiry outside frame");
endmodule : bch_cfg_chk
bind bch_config_regs bch_cfg_chk chk(.mclk, .arst_n, .cfgSel, .cfgWrite, .cfgAddr, .cfgRdData,
  .frameActive, .latTimerExpired, .latTimerEnabled, .lineSizeWords, .lineSizeMask, .prefetchWords);

// *** verification/bch_cfg_master.sv ***
// primary bus configuration master model
module bch_cfg_master (
  // clock
  input wire logic mclk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cfgSel, cfgWrite;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn_n;
  logic [31:0] cfgWrData;
  initial {cfgSel, cfgWrite, cfgAddr, cfgByteEn_n, cfgWrData} = '0;
  // one-cycle access from the primary side; on release address and data invert, cfgWrite and byte enables hold
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge mclk);
    {cfgSel, cfgWrite, cfgAddr, cfgByteEn_n, cfgWrData} <= {1'b1, w, a, b, d};
    @(posedge mclk);
    {cfgSel, cfgAddr, cfgWrData} <= {1'b0, ~a, ~d};
  endtask : acc
endmodule : bch_cfg_master

// *** verification/tb.sv ***
// self-checking bench for the config header registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, arst_n = 0, frameStart = 0, frameActive = 0, latTimerExpired, latTimerEnabled;
  logic mwiLineEnd;
  logic [7:0] burstWordCount = 0, lineSizeWords, lineSizeMask, prefetchWords, a, e;
  logic [31:0] cfgRdData;
  logic [4:0] lat = 0;
  logic [7:0] cls = 0;
  logic [3:0] be;
  logic [31:0] d;
  int badCount = 0, comparisons = 0, cyc = 0;
  bch_cfg_master m(.mclk(mclk));
  bch_config_regs #(.REVISION(8'h5a)) uut(.mclk, .arst_n, .cfgSel(m.cfgSel),
    .cfgWrite(m.cfgWrite), .cfgAddr(m.cfgAddr), .cfgByteEn_n(m.cfgByteEn_n),
    .cfgWrData(m.cfgWrData), .cfgRdData, .frameStart, .frameActive, .latTimerExpired,
    .latTimerEnabled, .lineSizeWords, .lineSizeMask, .burstWordCount, .mwiLineEnd,
    .prefetchWords);
  always #20 mclk = ~mclk;
  function automatic logic [31:0] expRd(input logic [7:0] x);
    if (x == 8'h08) return 32'h0604005a;
    if (x == 8'h0c) return {16'h0001, lat, 3'h0, cls};
    return 32'h0;
  endfunction : expRd
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tallyAndFinish
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      badCount++;
      tallyAndFinish();
    end
  end
  initial begin
    void'($urandom(79048));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    repeat (60) begin
      a = 8'h08 + 8'(($urandom % 5) * 4);
      be = 4'($urandom);
      d = $urandom;
      m.acc(1'b1, a, be, d);
      // byte lanes are active low; lanes 2 and 3 are all read-only
      if (a == 8'h0c && !be[1]) lat = d[15:11];
      if (a == 8'h0c && !be[0]) cls = d[7:0];
      burstWordCount <= 8'($urandom);
      m.acc(1'b0, a, 4'h0, 32'h0);
      @(negedge mclk);
      chk("read", expRd(a), cfgRdData);
      e = 8'h0;
      for (int i = 0; i < 8; i++) if (cls[i]) e = 8'h01 << i;
      chk("size", {e, e - 8'h01, e, lat != 0, e != 0 && (burstWordCount & (e - 8'h01)) ==
        e - 8'h01}, {lineSizeWords, lineSizeMask, prefetchWords, latTimerEnabled, mwiLineEnd});
    end
    // mid-run reset must clear both writable fields
    @(posedge mclk) arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    lat = 5'h00;
    cls = 8'h00;
    repeat (3) @(posedge mclk);
    m.acc(1'b0, 8'h0c, 4'h0, 32'h0);
    @(negedge mclk) chk("reset", expRd(8'h0c), cfgRdData);
    // zero limit: a long frame never expires
    @(posedge mclk) {frameStart, frameActive} <= 2'b11;
    @(posedge mclk) frameStart <= 1'b0;
    repeat (10) @(posedge mclk);
    @(negedge mclk) chk("zero limit", 0, latTimerExpired);
    @(posedge mclk) frameActive <= 1'b0;
    m.acc(1'b1, 8'h0c, 4'h0, 32'h0800);
    @(posedge mclk) {frameStart, frameActive} <= 2'b11;
    @(posedge mclk) frameStart <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk) chk("early", 0, latTimerExpired);
    repeat (6) @(posedge mclk);
    @(negedge mclk) chk("expired", 1, latTimerExpired);
    @(posedge mclk) frameActive <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk) chk("dropped", 0, latTimerExpired);
    tallyAndFinish();
  end
endmodule : tb
